// ---- logic/dhp_positioner.sv ----
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/10ps
// How it works
// - with disk up to speed and no bad track, step outward toward track 00
// - track 00 reached during recalibration sets ready and stops stepping
// - ready goes to the controller only while this unit is selected
// - own 8-bit target latch in two halves; seek reaches selected unit only
// - qualified seek leading edge loads the presented address into target
// - loss of speed or disk removal clears the target latch
// - a target of zero forces recalibration onto track 00
// - targets above 87 are illegal and raise the bad track flag
// - bad track flag is clocked on the trailing edge of the seek pulse
// - bad track flag is multiplexed to the controller by unit select
// - bad track flag blocks step pulses from the sequencing register while ready
// - current track counter follows steps and recalibrates at track 00
// - counter is two cascaded 4-bit up/down halves, direction high is up
// - counter clears at track 00 and counts only once ready
// - comparator gives greater, less and equal of target versus current
// - two cascaded 5-bit compare stages, outputs low until ready
// - one winding at a time; all off once heads have settled
// - sequencing register homes at track 00, moves one place per step
// - winding follows track modulo three: residue 0, 1, 2 to outputs 0-2
// - step clock runs while tracks differ or drive not ready
// - step interval ramps from 6.8 ms down to 4.5 ms per movement
// - settle timer retriggered by seek and steps, settled 50 ms later
// - disk removed at track 00 steps the carriage one track inward, to track 1
module dhp_positioner #(
  parameter logic [23:0] SLOW_CYC = 24'(dhp_pkg::STEP_SLOW_CYC),
  parameter logic [23:0] FAST_CYC = 24'(dhp_pkg::STEP_FAST_CYC),
  parameter logic [23:0] RAMP_DEC = 24'(dhp_pkg::RAMP_DEC_CYC),
  parameter logic [23:0] SETTLE_CYC = 24'(dhp_pkg::SETTLE_CYC)
) (
  input logic clock, // 250 MHz
  input logic rstn, // synchronous, active low
  input dhp_pkg::dhp_apb_req_s apb_req, // apb request
  output dhp_pkg::dhp_apb_rsp_s apb_rsp, // apb answer
  input logic disk_speed_ok, // disk in and up to speed
  input logic track00, // home sensor, high at track 00
  input logic seek_n, // seek pulse, active low
  input logic write_gate_n, // controller write gate, active low
  input logic unit_select, // this unit selected
  input logic [7:0] track_addr, // target track from controller
  input logic peer_ready, // ready of the other unit
  input logic peer_bad_track, // bad track flag of the other unit
  output logic [2:0] winding, // stepper winding drives
  output logic ctl_ready, // ready toward the controller
  output logic ctl_bad_track, // bad track toward the controller
  output logic heads_settled // heads settled on track
);
  import dhp_pkg::*;

  dhp_mode_e mode;
  dhp_mode_e next_mode;
  logic [7:0] target;
  logic bad_track;
  logic seek_q;
  logic seek_qual;
  logic seek_fall;
  logic seek_rise;
  logic [3:0] cur_lo;
  logic [3:0] cur_hi;
  logic [7:0] current;
  dhp_cmp_s cmp_lo;
  dhp_cmp_s cmp_raw;
  dhp_cmp_s cmp;
  logic drive_ready;
  logic target_zero;
  logic step_en;
  logic dir_up;
  logic step_tick;
  logic step_pass;
  logic step_ok;
  logic leaving_home;
  logic [1:0] seq;
  logic [23:0] step_cnt;
  logic [23:0] step_intv;
  logic [23:0] ramp_dec;
  logic [23:0] settle_cnt;
  logic timed_out;
  logic is_master;
  logic [31:0] rd_data;
  logic rd_hit;
  logic apb_setup;
  logic wr_ctrl;

  // one stage of the cascaded magnitude compare
  function automatic dhp_cmp_s cmp5(input logic [4:0] a, input logic [4:0] b,
                                    input dhp_cmp_s low);
    dhp_cmp_s r;
    r.gt = (a > b) | ((a == b) & low.gt);
    r.lt = (a < b) | ((a == b) & low.lt);
    r.eq = (a == b) & low.eq;
    return r;
  endfunction

  // drive mode

  assign drive_ready = (mode == MODE_READY);

  always_comb begin
    next_mode = mode;
    unique case (mode)
      MODE_NO_DISK: begin
        if (disk_speed_ok && !bad_track) begin
          next_mode = MODE_RECAL;
        end
      end
      MODE_RECAL: begin
        if (track00) begin
          next_mode = MODE_READY;
        end
      end
      MODE_READY: begin
        next_mode = MODE_READY;
      end
      default: begin
        next_mode = MODE_NO_DISK;
      end
    endcase
    if (!disk_speed_ok) begin
      next_mode = MODE_NO_DISK;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      mode <= MODE_NO_DISK;
    end else begin
      mode <= next_mode;
    end
  end

  // seek pulse and target latch

  assign seek_qual = unit_select & write_gate_n;
  assign seek_fall = seek_q & ~seek_n & seek_qual;
  assign seek_rise = ~seek_q & seek_n & seek_qual;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      seek_q <= 1'b1;
    end else begin
      seek_q <= seek_n;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      target <= HOME_TRACK;
    end else if (!disk_speed_ok) begin
      target <= HOME_TRACK;
    end else if (seek_fall) begin
      target <= track_addr;
    end
  end

  assign target_zero = (target == HOME_TRACK);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      bad_track <= 1'b0;
    end else if (!disk_speed_ok) begin
      bad_track <= 1'b0;
    end else if (seek_rise) begin
      bad_track <= (target > LAST_TRACK);
    end
  end

  // current track counter and comparator

  assign current = {cur_hi, cur_lo};

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cur_lo <= 4'h0;
      cur_hi <= 4'h0;
    end else if (track00 && !step_ok && !leaving_home) begin
      cur_lo <= 4'h0;
      cur_hi <= 4'h0;
    end else if (step_ok && drive_ready) begin
      if (dir_up) begin
        cur_lo <= cur_lo + 4'h1;
        if (cur_lo == 4'hf) begin
          cur_hi <= cur_hi + 4'h1;
        end
      end else begin
        cur_lo <= cur_lo - 4'h1;
        if (cur_lo == 4'h0) begin
          cur_hi <= cur_hi - 4'h1;
        end
      end
    end
  end

  always_comb begin
    cmp_lo = cmp5({1'b0, target[3:0]}, {1'b0, cur_lo}, 3'b001);
    cmp_raw = cmp5({1'b0, target[7:4]}, {1'b0, cur_hi}, cmp_lo);
    cmp = drive_ready ? cmp_raw : 3'b000;
  end

  // step clock control, direction and gating

  always_comb begin
    step_en = !drive_ready || !cmp.eq;
    if (drive_ready && target_zero && !track00) begin
      step_en = 1'b1;
    end
    if (!disk_speed_ok && track00) begin
      step_en = 1'b1;
    end
  end

  always_comb begin
    if (!disk_speed_ok) begin
      dir_up = track00;
    end else begin
      dir_up = drive_ready && cmp.gt && !target_zero;
    end
  end

  assign ramp_dec = (RAMP_DEC == 24'h0) ? 24'h1 : RAMP_DEC;

  always_ff @(posedge clock) begin
    if (!rstn || !step_en) begin
      step_cnt <= 24'h0;
      step_intv <= SLOW_CYC;
    end else if (step_cnt == 24'h0) begin
      step_cnt <= step_intv - 24'h1;
      if (step_intv > FAST_CYC + ramp_dec) begin
        step_intv <= step_intv - ramp_dec;
      end else begin
        step_intv <= FAST_CYC;
      end
    end else begin
      step_cnt <= step_cnt - 24'h1;
    end
  end

  assign step_tick = step_en && (step_cnt == 24'h0);
  // an illegal target is held off at once, before the flag is clocked
  assign step_pass = (disk_speed_ok &&
                      !((bad_track || target > LAST_TRACK) && drive_ready)) ||
                     (!disk_speed_ok && track00);
  assign step_ok = step_tick && step_pass;

  // sensor lags an inward step off home; homing then would undo the step
  always_ff @(posedge clock) begin
    if (!rstn) begin
      leaving_home <= 1'b0;
    end else if (step_ok && dir_up && track00) begin
      leaving_home <= 1'b1;
    end else if (!track00) begin
      leaving_home <= 1'b0;
    end
  end

  // stepper sequencing register and windings

  always_ff @(posedge clock) begin
    if (!rstn) begin
      seq <= SEQ_RES0;
    end else if (step_ok) begin
      if (dir_up) begin
        seq <= (seq == SEQ_RES2) ? SEQ_RES0 : seq + 2'h1;
      end else begin
        seq <= (seq == SEQ_RES0) ? SEQ_RES2 : seq - 2'h1;
      end
    end else if (track00 && !leaving_home) begin
      seq <= SEQ_RES0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      settle_cnt <= 24'h0;
    end else if (step_ok || seek_fall) begin
      settle_cnt <= SETTLE_CYC;
    end else if (settle_cnt != 24'h0) begin
      settle_cnt <= settle_cnt - 24'h1;
    end
  end

  assign timed_out = (settle_cnt == 24'h0);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_winding
      always_ff @(posedge clock) begin
        if (!rstn) begin
          winding[gi] <= 1'b0;
        end else begin
          winding[gi] <= !timed_out && (seq == 2'(gi));
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rstn) begin
      heads_settled <= 1'b0;
    end else begin
      heads_settled <= drive_ready && timed_out && !step_en;
    end
  end

  // controller side multiplexing

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctl_ready <= 1'b0;
      ctl_bad_track <= 1'b0;
    end else if (unit_select) begin
      ctl_ready <= drive_ready;
      ctl_bad_track <= bad_track;
    end else begin
      ctl_ready <= is_master && peer_ready;
      ctl_bad_track <= is_master && peer_bad_track;
    end
  end

  // apb slave

  assign apb_setup = apb_req.psel && !apb_req.penable;
  assign wr_ctrl = apb_req.psel && apb_req.penable && apb_rsp.pready &&
                   apb_req.pwrite && ({apb_req.paddr[7:2], 2'b00} == REG_CTRL);

  always_comb begin
    rd_data = 32'h0;
    rd_hit = 1'b1;
    case ({apb_req.paddr[7:2], 2'b00})
      REG_CTRL: begin
        rd_data[CTRL_MASTER_BIT] = is_master;
      end
      REG_STATUS: begin
        rd_data[ST_READY_BIT] = drive_ready;
        rd_data[ST_BAD_BIT] = bad_track;
        rd_data[ST_GT_BIT] = cmp.gt;
        rd_data[ST_LT_BIT] = cmp.lt;
        rd_data[ST_EQ_BIT] = cmp.eq;
        rd_data[ST_SETTLED_BIT] = heads_settled;
        rd_data[ST_DIR_UP_BIT] = dir_up;
        rd_data[ST_SEQ_LSB +: 2] = seq;
      end
      REG_TRACK: begin
        rd_data[TRK_TARGET_LSB +: 8] = target;
        rd_data[TRK_CURRENT_LSB +: 8] = current;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      apb_rsp <= '0;
    end else begin
      apb_rsp.pready <= apb_setup;
      if (apb_setup) begin
        apb_rsp.prdata <= apb_req.pwrite ? 32'h0 : rd_data;
        apb_rsp.pslverr <= !rd_hit;
      end else if (!apb_req.psel) begin
        apb_rsp.prdata <= 32'h0;
        apb_rsp.pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      is_master <= CTRL_MASTER_RESET;
    end else if (wr_ctrl) begin
      is_master <= apb_req.pwdata[CTRL_MASTER_BIT];
    end
  end

  // checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  property p_recal_steps_down;
    (mode == MODE_RECAL) && disk_speed_ok && !track00 |-> step_en && !dir_up;
  endproperty
  a_recal_steps_down: assert property (p_recal_steps_down)
    else $error("recalibration does not step outward");

  property p_ready_at_home;
    (mode == MODE_RECAL) && track00 && disk_speed_ok |=> drive_ready;
  endproperty
  a_ready_at_home: assert property (p_ready_at_home)
    else $error("ready did not set at track 00");

  property p_ready_unselected;
    !unit_select && !is_master |=> !ctl_ready && !ctl_bad_track;
  endproperty
  a_ready_unselected: assert property (p_ready_unselected)
    else $error("unselected unit drives controller status");

  property p_ready_selected;
    unit_select |=> ctl_ready == $past(drive_ready);
  endproperty
  a_ready_selected: assert property (p_ready_selected)
    else $error("selected unit ready not presented");

  property p_seek_load;
    seek_fall && disk_speed_ok |=> target == $past(track_addr);
  endproperty
  a_seek_load: assert property (p_seek_load)
    else $error("seek leading edge did not load target");

  property p_speed_clear;
    !disk_speed_ok |=> target == HOME_TRACK && !bad_track;
  endproperty
  a_speed_clear: assert property (p_speed_clear)
    else $error("target not cleared on speed loss");

  property p_bad_track;
    seek_rise && disk_speed_ok |=> bad_track == ($past(target) > LAST_TRACK);
  endproperty
  a_bad_track: assert property (p_bad_track)
    else $error("bad track flag wrong after seek");

  property p_bad_blocks;
    bad_track && drive_ready && disk_speed_ok |-> !step_ok;
  endproperty
  a_bad_blocks: assert property (p_bad_blocks)
    else $error("step passed while bad track set");

  property p_count_up;
    step_ok && drive_ready && dir_up && !track00 |=>
      current == $past(current) + 8'h1;
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("counter did not advance up with step");

  property p_cmp_held;
    !drive_ready |-> cmp == 3'b000;
  endproperty
  a_cmp_held: assert property (p_cmp_held)
    else $error("comparator active before ready");

  property p_one_winding;
    $onehot0(winding);
  endproperty
  a_one_winding: assert property (p_one_winding)
    else $error("winding drive not one hot");

  property p_windings_off;
    timed_out |=> winding == 3'b000;
  endproperty
  a_windings_off: assert property (p_windings_off)
    else $error("windings still driven after settle");

  property p_seq_home;
    track00 && !step_ok && !leaving_home |=> seq == SEQ_RES0;
  endproperty
  a_seq_home: assert property (p_seq_home)
    else $error("sequencer not homed at track 00");

  property p_settle_retrig;
    step_ok |=> settle_cnt == SETTLE_CYC ##1 !timed_out;
  endproperty
  a_settle_retrig: assert property (p_settle_retrig)
    else $error("settle timer not retriggered by step");

  c_ready: cover property ($rose(drive_ready));
  c_bad: cover property ($rose(bad_track));
  c_seek_done: cover property (drive_ready && step_ok ##[1:1000] cmp.eq);
  c_settled: cover property ($rose(heads_settled));

endmodule // dhp_positioner

// ---- inc/dhp_pkg.sv ----
package dhp_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int STEP_SLOW_US = 6800;
  localparam int STEP_FAST_US = 4500;
  localparam int SETTLE_US = 50000;
  localparam int RAMP_STEPS = 4;
  localparam int STEP_SLOW_CYC =
    (STEP_SLOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_FAST_CYC =
    (STEP_FAST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC =
    (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_DEC_CYC = (STEP_SLOW_CYC - STEP_FAST_CYC) / RAMP_STEPS;
  localparam int TIMER_W = 24;

  // tracks
  localparam logic [7:0] HOME_TRACK = 8'h00;
  localparam logic [7:0] LAST_TRACK = 8'h57;

  // sequencing register states, one per track residue modulo three
  localparam logic [1:0] SEQ_RES0 = 2'h0;
  localparam logic [1:0] SEQ_RES1 = 2'h1;
  localparam logic [1:0] SEQ_RES2 = 2'h2;

  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TRACK = 8'h08;
  localparam logic CTRL_MASTER_RESET = 1'h0;
  localparam int CTRL_MASTER_BIT = 0;
  localparam int ST_READY_BIT = 0;
  localparam int ST_BAD_BIT = 1;
  localparam int ST_GT_BIT = 2;
  localparam int ST_LT_BIT = 3;
  localparam int ST_EQ_BIT = 4;
  localparam int ST_SETTLED_BIT = 5;
  localparam int ST_DIR_UP_BIT = 6;
  localparam int ST_SEQ_LSB = 8;
  localparam int TRK_TARGET_LSB = 0;
  localparam int TRK_CURRENT_LSB = 8;

  typedef enum logic [1:0] {
    MODE_NO_DISK = 2'b00,
    MODE_RECAL = 2'b01,
    MODE_READY = 2'b10
  } dhp_mode_e;

  typedef struct packed {
    logic gt;
    logic lt;
    logic eq;
  } dhp_cmp_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dhp_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dhp_apb_rsp_s;

endpackage

// ---- testbench/dhp_carriage.sv ----
`timescale 1ns/10ps
// carriage and home sensor: position follows the winding rotation
module dhp_carriage #(
  parameter int START_POS = 5
) (
  input wire logic clock, // bench clock
  input wire logic [2:0] winding, // winding drives from the design
  output logic track00, // high while carriage sits on track 00
  output int pos // carriage position in tracks
);
  logic [2:0] last;
  initial begin
    pos = START_POS;
    // rotor starts aligned with the phase of its own track
    last = 3'(1 << (START_POS % 3));
  end
  // a new phase one place ahead moves toward the spindle, else outward
  always @(posedge clock) begin
    if (winding != 3'h0 && winding != last) begin
      if (winding == {last[1:0], last[2]}) begin
        pos <= pos + 1;
      end else begin
        pos <= pos - 1;
      end
      last <= winding;
    end
  end
  assign track00 = (pos == 0);
endmodule // dhp_carriage

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
module tb;
  import dhp_pkg::*;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic err;
  } dhp_note_s;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  dhp_apb_req_s apb_req = '0;
  dhp_apb_rsp_s apb_rsp;
  logic disk_speed_ok = 1'b0;
  logic seek_n = 1'b1;
  logic write_gate_n = 1'b1;
  logic unit_select = 1'b1;
  logic [7:0] track_addr = 8'h00;
  logic peer_ready = 1'b0;
  logic peer_bad_track = 1'b0;
  logic [2:0] winding;
  logic ctl_ready;
  logic ctl_bad_track;
  logic heads_settled;
  logic track00;
  int pos;
  int failures = 0;
  int n_checks = 0;
  int t;
  dhp_note_s note;
  dhp_note_s notes[$];
  logic [7:0] bad_list [4] = '{8'h58, 8'h5f, 8'h60, 8'hff};

  always #2 clock = ~clock;

  dhp_positioner #(
    .SLOW_CYC(24'd40),
    .FAST_CYC(24'd20),
    .RAMP_DEC(24'd5),
    .SETTLE_CYC(24'd100)
  ) i_dhp_positioner (
    .clock(clock),
    .rstn(rstn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .disk_speed_ok(disk_speed_ok),
    .track00(track00),
    .seek_n(seek_n),
    .write_gate_n(write_gate_n),
    .unit_select(unit_select),
    .track_addr(track_addr),
    .peer_ready(peer_ready),
    .peer_bad_track(peer_bad_track),
    .winding(winding),
    .ctl_ready(ctl_ready),
    .ctl_bad_track(ctl_bad_track),
    .heads_settled(heads_settled)
  );

  dhp_carriage #(.START_POS(5)) i_dhp_carriage (
    .clock(clock),
    .winding(winding),
    .track00(track00),
    .pos(pos)
  );

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
           input logic [31:0] exp, input logic [31:0] mask, input logic err);
    int k;
    notes.push_back('{exp, mask, err});
    apb_req.psel <= 1'b1;
    apb_req.pwrite <= wr;
    apb_req.paddr <= addr;
    apb_req.pwdata <= wd;
    @(posedge clock);
    apb_req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (apb_rsp.pready !== 1'b1 && k < 50);
    if (apb_rsp.pready !== 1'b1) begin
      failures++;
    end
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge clock);
  endtask

  // every completed transfer is judged against the oldest note
  always @(posedge clock) begin
    if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1) begin
      note = notes.pop_front();
      check(apb_rsp.prdata & note.mask, note.data & note.mask);
      check({31'h0, apb_rsp.pslverr}, {31'h0, note.err});
    end
  end

  // never two windings at once
  always @(posedge clock) begin
    if (rstn && $countones(winding) > 1) begin
      check({29'h0, winding}, 32'h0);
    end
  end

  task automatic wait_hi(ref logic s, input int limit);
    int k;
    k = 0;
    while (s !== 1'b1 && k < limit) begin
      @(posedge clock);
      k++;
    end
    if (k >= limit) begin
      failures++;
    end
    @(posedge clock);
  endtask

  task seek(input logic [7:0] a, input logic wg_n);
    track_addr <= a;
    write_gate_n <= wg_n;
    @(posedge clock);
    seek_n <= 1'b0;
    repeat (2) @(posedge clock);
    seek_n <= 1'b1;
    repeat (3) @(posedge clock);
    // address released once the pulse is over
    track_addr <= ~a;
    write_gate_n <= 1'b1;
    @(posedge clock);
  endtask

  task goto(input logic [7:0] a);
    seek(a, 1'b1);
    wait_hi(heads_settled, 20000);
    check(32'(pos), 32'(a));
    check({29'h0, winding}, 32'h0);
    apb(1'b0, REG_TRACK, 32'h0, {16'h0, a, a}, 32'hffffffff, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0, {22'h0, 2'(a % 3), 8'h31},
        32'hffffff3f, 1'b0);
  endtask

  initial begin
    void'($urandom(71));
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    check({26'h0, ctl_ready, ctl_bad_track, heads_settled, winding}, 0);
    apb(1'b0, REG_STATUS, 32'h0, 32'h0, 32'hffffff3f, 1'b0);
    apb(1'b0, REG_CTRL, 32'h0, 32'h0, 32'hffffffff, 1'b0);
    apb(1'b1, 8'h40, 32'h5, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 8'h40, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    disk_speed_ok <= 1'b1;
    wait_hi(ctl_ready, 2000);
    check(32'(pos), 32'h0);
    repeat (300) @(posedge clock);
    check(32'(pos), 32'h0);
    apb(1'b0, REG_TRACK, 32'h0, 32'h0, 32'hffffffff, 1'b0);
    unit_select <= 1'b0;
    peer_ready <= 1'b1;
    peer_bad_track <= 1'b1;
    repeat (3) @(posedge clock);
    check({31'h0, ctl_ready}, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1, 32'h0, 32'h0, 1'b0);
    apb(1'b0, REG_CTRL, 32'h0, 32'h1, 32'h1, 1'b0);
    check({30'h0, ctl_ready, ctl_bad_track}, 32'h3);
    peer_ready <= 1'b0;
    peer_bad_track <= 1'b0;
    unit_select <= 1'b1;
    repeat (3) @(posedge clock);
    check({30'h0, ctl_ready, ctl_bad_track}, 32'h2);
    apb(1'b1, REG_STATUS, 32'hffffffff, 32'h0, 32'h0, 1'b0);
    t = 1 + $urandom_range(29);
    goto(8'(t));
    goto(8'h57);
    t = 1 + $urandom_range(40);
    goto(8'(t));
    for (int i = 0; i < 4; i++) begin
      seek(bad_list[i], 1'b1);
      check({31'h0, ctl_bad_track}, 32'h1);
      repeat (100) @(posedge clock);
      check(32'(pos), 32'(t));
    end
    goto(8'h00);
    t = 10 + $urandom_range(20);
    goto(8'(t));
    seek(8'h03, 1'b0);
    repeat (100) @(posedge clock);
    check(32'(pos), 32'(t));
    apb(1'b0, REG_TRACK, 32'h0, {16'h0, 8'(t), 8'(t)}, 32'hffff, 1'b0);
    disk_speed_ok <= 1'b0;
    repeat (200) @(posedge clock);
    check(32'(pos), 32'(t));
    check({30'h0, ctl_ready, ctl_bad_track}, 32'h0);
    apb(1'b0, REG_TRACK, 32'h0, 32'h0, 32'hff, 1'b0);
    disk_speed_ok <= 1'b1;
    wait_hi(ctl_ready, 5000);
    check(32'(pos), 32'h0);
    disk_speed_ok <= 1'b0;
    repeat (300) @(posedge clock);
    check(32'(pos), 32'h1);
    give_verdict();
  end

  initial begin
    #(4 * 40000);
    failures++;
    give_verdict();
  end
endmodule // tb
